// [inc/mfup_pkg.sv]
// Shared constants, state types and decode functions of the frame user port.
package mfup_pkg;

   // ----------------------------------------------------------------
   // Channel geometry
   // ----------------------------------------------------------------
   localparam int LANE_COUNT = 2;
   localparam int LANE_BYTES = 2;
   localparam int WORD_BYTES = LANE_COUNT * LANE_BYTES;
   localparam int DATA_W = 8 * WORD_BYTES;

   // ----------------------------------------------------------------
   // Clock compensation timing, in bytes per lane and in user clocks
   // ----------------------------------------------------------------
   localparam int CC_INTERVAL_BYTES = 10000;
   localparam int CC_SEQ_BYTES = 12;
   localparam int CC_PERIOD_CLKS = CC_INTERVAL_BYTES / LANE_BYTES;
   localparam int CC_STALL_CLKS = CC_SEQ_BYTES / LANE_BYTES;
   localparam logic [2:0] CC_CNT_LAST = 3'(CC_STALL_CLKS - 1);
   localparam logic [15:0] CC_CNT_RESET = 16'h0000;

   // ----------------------------------------------------------------
   // Control character codes, sent with the lane control flag high
   // ----------------------------------------------------------------
   localparam logic [7:0] CODE_IDLE = 8'hbc;
   localparam logic [7:0] CODE_START1 = 8'h5c;
   localparam logic [7:0] CODE_START2 = 8'hfb;
   localparam logic [7:0] CODE_END1 = 8'hfd;
   localparam logic [7:0] CODE_END2 = 8'hfe;
   localparam logic [7:0] CODE_PAD = 8'h9c;
   localparam logic [7:0] CODE_CC = 8'hf7;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [31:0] IDLE_WORD = {4{CODE_IDLE}};
   localparam logic [3:0] CTRL_ALL = 4'hf;

   // ----------------------------------------------------------------
   // Transmit sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      TX_RUN = 2'b00,
      TX_TAIL = 2'b01,
      TX_CC = 2'b10
   } mfup_tx_state_e;

   // Number of valid bytes in a contiguous low-first byte-keep mask.
   function automatic logic [2:0] mfupKeepCount(input logic [3:0] keep);
      logic [2:0] cnt;
      cnt = 3'h0;
      for (int i = 0; i < 4; i++) begin
         if (keep[i]) begin
            cnt = 3'(i + 1);
         end
      end
      return cnt;
   endfunction

   // Contiguous low-first byte-keep mask for a byte count.
   function automatic logic [3:0] mfupCountMask(input int cnt);
      logic [3:0] mask;
      mask = 4'h0;
      for (int i = 0; i < 4; i++) begin
         if (i < cnt) begin
            mask[i] = 1'b1;
         end
      end
      return mask;
   endfunction

endpackage

// [verilog/mfup_cc_timer.sv]
// Clock compensation interval timer for the transmit sequencer.
`timescale 1ns/1ps
module mfup_cc_timer
   import mfup_pkg::*;
#(
   parameter int PERIOD = CC_PERIOD_CLKS
) (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic channelUp,
   input wire logic ccStart,
   output logic ccDue
);

   // ----------------------------------------------------------------
   // Interval counter
   // ----------------------------------------------------------------
   logic [15:0] count_reg;
   logic [15:0] count_next;
   logic due_reg;
   logic due_next;
   logic wrap;

   // The counter free-runs once the channel is up; a wrap that lands on
   // the very cycle the sequencer starts a sequence is kept pending.
   always_comb begin
      wrap = (count_reg == 16'(PERIOD - 1));
      count_next = wrap ? CC_CNT_RESET : count_reg + 16'h0001;
      due_next = (due_reg & ~ccStart) | wrap;
      if (!channelUp) begin
         count_next = CC_CNT_RESET;
         due_next = 1'b0;
      end
   end

   // Registers only.
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         count_reg <= CC_CNT_RESET;
         due_reg <= 1'b0;
      end else begin
         count_reg <= count_next;
         due_reg <= due_next;
      end
   end

   assign ccDue = due_reg;

endmodule

// [verilog/mfup_pair_class.sv]
// Classifies the received channel word into delimiter pairs and data bytes.
`timescale 1ns/1ps
module mfup_pair_class
   import mfup_pkg::*;
(
   input wire logic [31:0] laneData,
   input wire logic [3:0] laneCtrl,
   output logic [1:0] pairStart,
   output logic [1:0] pairEnd,
   output logic [3:0] byteIsData
);

   // ----------------------------------------------------------------
   // Per-pair decode
   // ----------------------------------------------------------------
   // Delimiters always arrive as aligned byte pairs, so only the two pair
   // slots are checked; any other control byte is simply not data.
   for (genvar p = 0; p < 2; p++) begin : gPair
      assign pairStart[p] = laneCtrl[2*p] & laneCtrl[2*p+1] &
         (laneData[16*p+:8] == CODE_START1) &
         (laneData[16*p+8+:8] == CODE_START2);
      assign pairEnd[p] = laneCtrl[2*p] & laneCtrl[2*p+1] &
         (laneData[16*p+:8] == CODE_END1) &
         (laneData[16*p+8+:8] == CODE_END2);
      assign byteIsData[2*p] = ~laneCtrl[2*p];
      assign byteIsData[2*p+1] = ~laneCtrl[2*p+1];
   end

endmodule

// [verilog/mfup_frame_port.sv]
// Framing user port: frame delimiting and striping on transmit, stripping
// and reassembly on receive.
//
// How it works
// - A transmit beat is taken only when valid and ready are both high.
// - Each taken beat is spread byte-wise over all lanes.
// - Stream content outside a frame never reaches the channel.
// - A two-byte start delimiter precedes the first data byte.
// - A two-byte end delimiter follows the last data byte.
// - Lanes carry idles whenever no user data, end delimiter or compensation sequence is to be sent.
// - An odd byte count gets one pad character after the last byte.
// - The top two bytes of each beat go out first in the next beat, or in the tail cycle after a last beat.
// - After a last beat ready drops one cycle for residue and end.
// - A 12-byte compensation sequence interrupts data every 10000 bytes.
// - Compensation recurs every 5000 clocks with 2-byte lanes.
// - Compensation stalls the user for six cycles with ready low.
// - Receive strips idle, compensation, delimiter and pad characters.
// - Receive has no buffer and no ready; data is pushed out.
// - Receive valid rises with the first assembled word of a frame.
// - Receive last is high with the final word of each non-empty frame.
// - Receive byte-keep gives valid bytes of the final word.
// - Receive valid may drop at any cycle inside a frame.
// - Receive last is high for exactly one cycle per non-empty frame.
`timescale 1ns/1ps
module mfup_frame_port
   import mfup_pkg::*;
#(
   parameter int CC_PERIOD = CC_PERIOD_CLKS
) (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic channelUp,
   input wire logic [31:0] txData,
   input wire logic [3:0] txKeep,
   input wire logic txLast,
   input wire logic txValid,
   output logic txReady,
   output logic [31:0] txLaneData,
   output logic [3:0] txLaneCtrl,
   input wire logic [31:0] rxLaneData,
   input wire logic [3:0] rxLaneCtrl,
   output logic [31:0] rxData,
   output logic [3:0] rxKeep,
   output logic rxLast,
   output logic rxValid
);

   // ----------------------------------------------------------------
   // Transmit state
   // ----------------------------------------------------------------
   mfup_tx_state_e state_reg;
   mfup_tx_state_e state_next;
   logic txInFrame_reg;
   logic txInFrame_next;
   logic [15:0] residue_reg;
   logic [15:0] residue_next;
   logic [31:0] tail_reg;
   logic [31:0] tail_next;
   logic [3:0] tailCtrl_reg;
   logic [3:0] tailCtrl_next;
   logic [2:0] ccCnt_reg;
   logic [2:0] ccCnt_next;
   logic [31:0] txLaneData_reg;
   logic [31:0] txLaneData_next;
   logic [3:0] txLaneCtrl_reg;
   logic [3:0] txLaneCtrl_next;
   logic ccDue;
   logic ccStart;
   logic txAccept;
   logic [63:0] seqData;
   logic [7:0] seqCtrl;
   logic [63:0] txDataWide;

   // ----------------------------------------------------------------
   // Compensation interval timer
   // ----------------------------------------------------------------
   mfup_cc_timer #(
      .PERIOD(CC_PERIOD)
   ) uTimer (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .channelUp(channelUp),
      .ccStart(ccStart),
      .ccDue(ccDue)
   );

   // Ready is withheld while the channel is down, during the tail cycle
   // and while a compensation sequence is due or running.
   assign txReady = channelUp & (state_reg == TX_RUN) & ~ccDue;
   assign txAccept = txValid & txReady;
   assign txDataWide = {32'h0000_0000, txData};

   // ----------------------------------------------------------------
   // Eight-byte channel sequence for the beat being taken
   // ----------------------------------------------------------------
   // Bytes 0..3 go out with the beat, bytes 4..7 in the tail cycle of a
   // last beat. Building the full sequence in one place keeps the pad and
   // end-delimiter placement pair aligned for every keep value.
   always_comb begin
      int kc;
      int pd;
      int rel;
      kc = txLast ? int'(mfupKeepCount(txKeep)) : WORD_BYTES;
      pd = kc % 2;
      rel = 0;
      seqData = 64'h0;
      seqCtrl = 8'h00;
      for (int j = 0; j < 8; j++) begin
         rel = j - 2;
         if (j < 2) begin
            if (txInFrame_reg) begin
               seqData[8*j+:8] = residue_reg[8*j+:8];
               seqCtrl[j] = 1'b0;
            end else begin
               seqData[8*j+:8] = (j == 0) ? CODE_START1 : CODE_START2;
               seqCtrl[j] = 1'b1;
            end
         end else if (rel < kc) begin
            seqData[8*j+:8] = txDataWide[8*rel+:8];
            seqCtrl[j] = 1'b0;
         end else if ((pd == 1) && (rel == kc)) begin
            seqData[8*j+:8] = CODE_PAD;
            seqCtrl[j] = 1'b1;
         end else if (rel == kc + pd) begin
            seqData[8*j+:8] = CODE_END1;
            seqCtrl[j] = 1'b1;
         end else if (rel == kc + pd + 1) begin
            seqData[8*j+:8] = CODE_END2;
            seqCtrl[j] = 1'b1;
         end else begin
            seqData[8*j+:8] = CODE_IDLE;
            seqCtrl[j] = 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Transmit sequencer next state
   // ----------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      txInFrame_next = txInFrame_reg;
      residue_next = residue_reg;
      tail_next = tail_reg;
      tailCtrl_next = tailCtrl_reg;
      ccCnt_next = ccCnt_reg;
      ccStart = 1'b0;
      txLaneData_next = IDLE_WORD;
      txLaneCtrl_next = CTRL_ALL;
      if (!channelUp) begin
         state_next = TX_RUN;
         txInFrame_next = 1'b0;
         ccCnt_next = 3'h0;
      end else begin
         case (state_reg)
            TX_RUN: begin
               if (ccDue) begin
                  // First of the stall cycles; the sequence starts here.
                  state_next = TX_CC;
                  ccStart = 1'b1;
                  ccCnt_next = 3'h1;
                  txLaneData_next = {4{CODE_CC}};
               end else if (txAccept) begin
                  txLaneData_next = seqData[31:0];
                  txLaneCtrl_next = seqCtrl[3:0];
                  if (txLast) begin
                     state_next = TX_TAIL;
                     tail_next = seqData[63:32];
                     tailCtrl_next = seqCtrl[7:4];
                     txInFrame_next = 1'b0;
                  end else begin
                     txInFrame_next = 1'b1;
                     residue_next = txData[31:16];
                  end
               end
               // Without a beat the lanes idle; a half-sent frame keeps
               // its residue until the user resumes.
            end
            TX_TAIL: begin
               txLaneData_next = tail_reg;
               txLaneCtrl_next = tailCtrl_reg;
               state_next = TX_RUN;
            end
            TX_CC: begin
               txLaneData_next = {4{CODE_CC}};
               ccCnt_next = ccCnt_reg + 3'h1;
               if (ccCnt_reg == CC_CNT_LAST) begin
                  state_next = TX_RUN;
                  ccCnt_next = 3'h0;
               end
            end
            default: begin
               state_next = TX_RUN;
            end
         endcase
      end
   end

   // Transmit registers only.
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         state_reg <= TX_RUN;
         txInFrame_reg <= 1'b0;
         residue_reg <= 16'h0000;
         tail_reg <= IDLE_WORD;
         tailCtrl_reg <= CTRL_ALL;
         ccCnt_reg <= 3'h0;
         txLaneData_reg <= IDLE_WORD;
         txLaneCtrl_reg <= CTRL_ALL;
      end else begin
         state_reg <= state_next;
         txInFrame_reg <= txInFrame_next;
         residue_reg <= residue_next;
         tail_reg <= tail_next;
         tailCtrl_reg <= tailCtrl_next;
         ccCnt_reg <= ccCnt_next;
         txLaneData_reg <= txLaneData_next;
         txLaneCtrl_reg <= txLaneCtrl_next;
      end
   end

   assign txLaneData = txLaneData_reg;
   assign txLaneCtrl = txLaneCtrl_reg;

   // ----------------------------------------------------------------
   // Receive state
   // ----------------------------------------------------------------
   logic [1:0] pairStart;
   logic [1:0] pairEnd;
   logic [3:0] byteIsData;
   logic rxInFrame_reg;
   logic rxInFrame_next;
   logic [63:0] acc_reg;
   logic [63:0] acc_next;
   logic [2:0] accCnt_reg;
   logic [2:0] accCnt_next;
   logic [31:0] pend_reg;
   logic [31:0] pend_next;
   logic [3:0] pendKeep_reg;
   logic [3:0] pendKeep_next;
   logic pendValid_reg;
   logic pendValid_next;
   logic [31:0] rxData_reg;
   logic [31:0] rxData_next;
   logic [3:0] rxKeep_reg;
   logic [3:0] rxKeep_next;
   logic rxLast_reg;
   logic rxLast_next;
   logic rxValid_reg;
   logic rxValid_next;

   mfup_pair_class uClass (
      .laneData(rxLaneData),
      .laneCtrl(rxLaneCtrl),
      .pairStart(pairStart),
      .pairEnd(pairEnd),
      .byteIsData(byteIsData)
   );

   // ----------------------------------------------------------------
   // Receive strip, left-align and word assembly
   // ----------------------------------------------------------------
   // There is no buffer: at most one frame end can spill into a second
   // word, and that word is parked one cycle in the pending register. A
   // following frame cannot fill a word in that cycle because its start
   // delimiter takes a pair of the channel word.
   always_comb begin
      logic [63:0] wacc;
      int n;
      logic fr;
      logic endHit;
      wacc = acc_reg;
      n = int'(accCnt_reg);
      fr = rxInFrame_reg;
      endHit = 1'b0;
      for (int p = 0; p < 2; p++) begin
         if (pairStart[p]) begin
            fr = 1'b1;
         end else if (pairEnd[p]) begin
            endHit = fr;
            fr = 1'b0;
         end else if (fr) begin
            for (int b = 0; b < 2; b++) begin
               if (byteIsData[2*p+b]) begin
                  wacc[8*n+:8] = rxLaneData[16*p+8*b+:8];
                  n = n + 1;
               end
            end
         end
      end
      rxInFrame_next = fr;
      acc_next = wacc;
      accCnt_next = 3'(n);
      pend_next = pend_reg;
      pendKeep_next = pendKeep_reg;
      pendValid_next = 1'b0;
      rxData_next = rxData_reg;
      rxKeep_next = rxKeep_reg;
      rxLast_next = 1'b0;
      rxValid_next = 1'b0;
      if (pendValid_reg) begin
         rxData_next = pend_reg;
         rxKeep_next = pendKeep_reg;
         rxLast_next = 1'b1;
         rxValid_next = 1'b1;
      end else if (endHit && (n > 0)) begin
         rxData_next = wacc[31:0];
         rxValid_next = 1'b1;
         if (n <= WORD_BYTES) begin
            rxKeep_next = mfupCountMask(n);
            rxLast_next = 1'b1;
         end else begin
            pend_next = wacc[63:32];
            pendKeep_next = mfupCountMask(n - WORD_BYTES);
            pendValid_next = 1'b1;
         end
         acc_next = 64'h0;
         accCnt_next = 3'h0;
      end else if (endHit) begin
         acc_next = 64'h0; // An empty frame delivers nothing.
         accCnt_next = 3'h0;
      end else if (n >= WORD_BYTES) begin
         rxData_next = wacc[31:0];
         rxValid_next = 1'b1;
         acc_next = {32'h0000_0000, wacc[63:32]};
         accCnt_next = 3'(n - WORD_BYTES);
      end
      if (!channelUp) begin
         rxInFrame_next = 1'b0;
         acc_next = 64'h0;
         accCnt_next = 3'h0;
         pendValid_next = 1'b0;
         rxLast_next = 1'b0;
         rxValid_next = 1'b0;
      end
   end

   // Receive registers only.
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         rxInFrame_reg <= 1'b0;
         acc_reg <= 64'h0;
         accCnt_reg <= 3'h0;
         pend_reg <= 32'h0000_0000;
         pendKeep_reg <= 4'h0;
         pendValid_reg <= 1'b0;
         rxData_reg <= 32'h0000_0000;
         rxKeep_reg <= 4'h0;
         rxLast_reg <= 1'b0;
         rxValid_reg <= 1'b0;
      end else begin
         rxInFrame_reg <= rxInFrame_next;
         acc_reg <= acc_next;
         accCnt_reg <= accCnt_next;
         pend_reg <= pend_next;
         pendKeep_reg <= pendKeep_next;
         pendValid_reg <= pendValid_next;
         rxData_reg <= rxData_next;
         rxKeep_reg <= rxKeep_next;
         rxLast_reg <= rxLast_next;
         rxValid_reg <= rxValid_next;
      end
   end

   assign rxData = rxData_reg;
   assign rxKeep = rxKeep_reg;
   assign rxLast = rxLast_reg;
   assign rxValid = rxValid_reg;

endmodule

// [testbench/mfup_app_model.sv]
// Application-side frame source for the transmit stream port.
`timescale 1ns/1ps
module mfup_app_model (
   input wire logic core_clk,
   input wire logic txReady,
   output logic [31:0] txData,
   output logic [3:0] txKeep,
   output logic txLast,
   output logic txValid,
   output logic hung
);
   initial begin
      txData = 32'h0;
      txKeep = 4'h0;
      txLast = 1'b0;
      txValid = 1'b0;
      hung = 1'b0;
   end

   // Payload byte j of every frame.
   function automatic logic [7:0] byteVal(input int j);
      return 8'(j * 3 + 1);
   endfunction

   // Sends n bytes; beat pauseAt follows three cycles with valid low.
   task automatic sendFrame(input int n, input int pauseAt);
      int k;
      int w;
      @(posedge core_clk);
      for (int b = 0; b * 4 < n; b++) begin
         if (b == pauseAt) begin
            txValid <= 1'b0;
            txData <= ~txData;
            repeat (3) @(posedge core_clk);
         end
         k = n - b * 4;
         for (int i = 0; i < 4; i++)
            txData[8*i +: 8] <= byteVal(b * 4 + i);
         txKeep <= (k >= 4) ? 4'hf : 4'((1 << k) - 1);
         txLast <= k <= 4;
         txValid <= 1'b1;
         w = 0;
         // The beat is held until ready is seen high at an edge.
         do begin
            @(posedge core_clk);
            w++;
         end while (txReady !== 1'b1 && w < 200);
         hung <= hung || w >= 200;
      end
      // A released bus shows the inverse of its last value.
      txValid <= 1'b0;
      txLast <= 1'b0;
      txData <= ~txData;
   endtask
endmodule

// [testbench/mfup_frame_port_sva.sv]
// Concurrent checks on the ports of the frame user port.
`timescale 1ns/1ps
module mfup_frame_port_sva
   import mfup_pkg::*;
#(
   parameter int CC_PERIOD = CC_PERIOD_CLKS
) (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic channelUp,
   input wire logic [3:0] txKeep,
   input wire logic txLast,
   input wire logic txValid,
   input wire logic txReady,
   input wire logic [31:0] txLaneData,
   input wire logic [3:0] txLaneCtrl,
   input wire logic [3:0] rxKeep,
   input wire logic rxLast,
   input wire logic rxValid
);
   // ---------------
   // Helper state
   // ---------------
   logic inFrame_reg, inFrame_next;
   logic [3:0] lowRun_reg, lowRun_next;
   wire logic take = txValid && txReady;
   wire logic ccNow = txLaneData == {4{CODE_CC}} && txLaneCtrl == 4'hf;

   // Frame tracking, and a saturating count of refused cycles.
   always_comb begin
      inFrame_next = take ? !txLast : inFrame_reg;
      lowRun_next = 4'h0;
      if (channelUp && !txReady) begin
         lowRun_next = (lowRun_reg == 4'hf) ? 4'hf : lowRun_reg + 4'h1;
      end
   end
   always_ff @(posedge core_clk) begin
      inFrame_reg <= reset_n ? inFrame_next : 1'b0;
      lowRun_reg <= reset_n ? lowRun_next : 4'h0;
   end

   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);

   // Tail gap plus a compensation burst is the longest legal refusal.
   chk_stall_bound: assert property (lowRun_reg <= 4'h7)
      else $error("ready held low too long");
   chk_ready_down: assert property (!channelUp |-> !txReady)
      else $error("ready high while channel down");
   chk_rx_quiet: assert property (!channelUp |=> !rxValid)
      else $error("rx valid while channel down");
   chk_start_pair: assert property (take && !inFrame_reg |=>
      txLaneData[15:0] == 16'hfb5c && txLaneCtrl[2:0] == 3'h3)
      else $error("frame start pair missing");
   chk_start_only: assert property (!inFrame_reg && !take |=>
      !(txLaneData[15:0] == 16'hfb5c && txLaneCtrl[1:0] == 2'b11))
      else $error("start pair without a beat");
   chk_gap_after: assert property (take && txLast |=> !txReady)
      else $error("no gap after last beat");
   chk_end_pair: assert property (take && txLast && txKeep[2] |=> ##1
      txLaneData[31:16] == 16'hfefd && txLaneCtrl[3:2] == 2'b11)
      else $error("end pair misplaced");
   chk_pad_odd: assert property (take && txLast && txKeep == 4'h1 |=>
      txLaneData[31:24] == CODE_PAD && txLaneCtrl[3])
      else $error("pad missing");
   chk_cc_burst: assert property ($rose(ccNow) |-> ccNow [*6])
      else $error("compensation burst length wrong");
   chk_last_valid: assert property (rxLast |-> rxValid)
      else $error("rx last without valid");
   chk_last_once: assert property (rxLast |=> !rxLast)
      else $error("rx last longer than one cycle");
   chk_keep_form: assert property (rxLast |->
      rxKeep inside {4'h1, 4'h3, 4'h7, 4'hf})
      else $error("rx keep not contiguous");
endmodule

bind mfup_frame_port mfup_frame_port_sva #(.CC_PERIOD(CC_PERIOD)) u_sva (
   .core_clk(core_clk),
   .reset_n(reset_n),
   .channelUp(channelUp),
   .txKeep(txKeep),
   .txLast(txLast),
   .txValid(txValid),
   .txReady(txReady),
   .txLaneData(txLaneData),
   .txLaneCtrl(txLaneCtrl),
   .rxKeep(rxKeep),
   .rxLast(rxLast),
   .rxValid(rxValid)
);

// [testbench/mfup_frame_port_tb.sv]
// Self-checking bench of the frame user port with channel loopback.
`timescale 1ns/1ps
module mfup_frame_port_tb
   import mfup_pkg::*;
;
   logic core_clk = 1'b0;
   logic reset_n = 1'b0;
   logic channelUp = 1'b0;
   logic [31:0] txData, txLaneData, rxData;
   logic [31:0] rxLaneData = IDLE_WORD;
   logic [3:0] txKeep, txLaneCtrl, rxKeep, lastKeep;
   logic [3:0] rxLaneCtrl = CTRL_ALL;
   logic txLast, txValid, txReady, rxLast, rxValid, hung;
   int fails = 0;
   int tests_run = 0;
   int lastCnt = 0;
   logic [7:0] rxQ[$];

   always #25 core_clk = ~core_clk;

   // A short compensation period keeps bursts frequent in the run.
   mfup_frame_port #(.CC_PERIOD(40)) u_dut (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .channelUp(channelUp),
      .txData(txData),
      .txKeep(txKeep),
      .txLast(txLast),
      .txValid(txValid),
      .txReady(txReady),
      .txLaneData(txLaneData),
      .txLaneCtrl(txLaneCtrl),
      .rxLaneData(rxLaneData),
      .rxLaneCtrl(rxLaneCtrl),
      .rxData(rxData),
      .rxKeep(rxKeep),
      .rxLast(rxLast),
      .rxValid(rxValid)
   );

   mfup_app_model u_app (
      .core_clk(core_clk),
      .txReady(txReady),
      .txData(txData),
      .txKeep(txKeep),
      .txLast(txLast),
      .txValid(txValid),
      .hung(hung)
   );

   // Loop the channel back one cycle late and collect delivered bytes.
   always @(posedge core_clk) begin
      rxLaneData <= txLaneData;
      rxLaneCtrl <= txLaneCtrl;
      if (rxValid === 1'b1) begin
         for (int i = 0; i < 4; i++)
            if (!rxLast || rxKeep[i]) rxQ.push_back(rxData[8*i +: 8]);
         if (rxLast) begin
            lastCnt++;
            lastKeep = rxKeep;
         end
      end
   end

   task automatic check(input string what, input logic [31:0] exp,
                        input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic give_verdict();
      $display("fails %0d tests_run %0d", fails, tests_run);
      if (fails == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   // Compares the bytes of one delivered frame with those sent.
   task automatic rxCheck(input int n);
      for (int w = 0; w < 40 && lastCnt == 0; w++) @(posedge core_clk);
      @(posedge core_clk);
      check("rx count", 32'(n), 32'(rxQ.size()));
      for (int i = 0; i < n && i < rxQ.size(); i++)
         check("rx byte", 32'(u_app.byteVal(i)), 32'(rxQ[i]));
      check("rx last", 32'h1, 32'(lastCnt));
      check("rx keep", 32'((n % 4 == 0) ? 4'hf : 4'((1 << (n % 4)) - 1)),
            32'(lastKeep));
      rxQ.delete();
      lastCnt = 0;
   endtask

   task automatic testReset();
      repeat (20) @(posedge core_clk);
      reset_n <= 1'b1;
      @(posedge core_clk);
      #1;
      check("ready", 32'h0, 32'(txReady));
      check("idle", IDLE_WORD, txLaneData);
      check("idle ctrl", 32'(CTRL_ALL), 32'(txLaneCtrl));
      @(posedge core_clk);
      channelUp <= 1'b1;
   endtask

   // One three-byte frame, lane words checked cycle by cycle.
   task automatic testTail();
      int w;
      fork
         u_app.sendFrame(3, -1);
         begin
            w = 0;
            do begin
               @(posedge core_clk);
               w++;
            end while (!(txValid && txReady) && w < 50);
            #1;
            check("start", {u_app.byteVal(1), u_app.byteVal(0), 16'hfb5c},
                  txLaneData);
            check("start ctrl", 32'h3, 32'(txLaneCtrl));
            check("gap", 32'h0, 32'(txReady));
            @(posedge core_clk);
            #1;
            check("end", {16'hfefd, CODE_PAD, u_app.byteVal(2)},
                  txLaneData);
            check("end ctrl", 32'he, 32'(txLaneCtrl));
            check("reopen", 32'h1, 32'(txReady));
         end
      join
      rxCheck(3);
   endtask

   // Frame lengths cover every keep value; long ones pause mid-frame.
   task automatic testFrames();
      int lens[6] = '{1, 2, 4, 5, 11, 16};
      foreach (lens[i]) begin
         u_app.sendFrame(lens[i], (lens[i] > 8) ? 1 : -1);
         rxCheck(lens[i]);
      end
   endtask

   task automatic testCc();
      int w;
      int run;
      fork
         u_app.sendFrame(200, -1);
         begin
            w = 0;
            run = 0;
            // A burst already under way would be counted short; skip it.
            #1;
            while (w < 10 && txLaneData === {4{CODE_CC}}) begin
               @(posedge core_clk);
               #1;
               w++;
            end
            while (w < 100 && txLaneData !== {4{CODE_CC}}) begin
               @(posedge core_clk);
               #1;
               w++;
            end
            while (txLaneData === {4{CODE_CC}} && run < 20) begin
               run++;
               @(posedge core_clk);
               #1;
            end
            check("cc run", 32'(CC_STALL_CLKS), 32'(run));
         end
      join
      rxCheck(200);
   endtask

   initial begin
      testReset();
      testTail();
      testFrames();
      testCc();
      @(posedge core_clk);
      channelUp <= 1'b0;
      @(posedge core_clk);
      #1;
      check("ready off", 32'h0, 32'(txReady));
      check("source", 32'h0, 32'(hung));
      give_verdict();
   end
endmodule
